// *** hw/bank_cmd_regs.vh ***
// bank command legality: strobe encodings, state codes and timing counts
// assumes a 100 MHz system clock; included by the design and testbench files
`ifndef BANK_CMD_REGS_VH
`define BANK_CMD_REGS_VH

// ==========================================================
// command codes, {ras_n, cas_n, we_n} with select low
`define CMD_NOP 3'h7
`define CMD_ACT 3'h3
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4
`define CMD_TERM 3'h6
`define CMD_PRE 3'h2
`define CMD_REF 3'h1
`define CMD_MRS 3'h0

// ==========================================================
// bank state codes
`define BS_IDLE 3'h0
`define BS_ACTIVATING 3'h1
`define BS_ACTIVE 3'h2
`define BS_READ 3'h3
`define BS_WRITE 3'h4
`define BS_PRECHARGING 3'h5
`define BS_AUTO_PRE 3'h6

// ==========================================================
// device phases
`define DEV_NORMAL 2'h0
`define DEV_REFRESH 2'h1
`define DEV_MODE_LOAD 2'h2
`define DEV_SR_EXIT 2'h3

// ==========================================================
// times in ns and derived cycle counts at 10 ns per cycle
`define CLK_PERIOD_NS 10
`define PRECHARGE_PERIOD_NS 15
`define ACTIVATE_TO_ACCESS_DELAY_NS 15
`define REFRESH_CYCLE_PERIOD_NS 60
`define MODE_LOAD_DELAY_NS 20
`define SELF_REFRESH_EXIT_DELAY_NS 70
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_PERIOD_CYC `CYC_UP(`PRECHARGE_PERIOD_NS)
`define ACTIVATE_TO_ACCESS_DELAY_CYC `CYC_UP(`ACTIVATE_TO_ACCESS_DELAY_NS)
`define REFRESH_CYCLE_PERIOD_CYC `CYC_UP(`REFRESH_CYCLE_PERIOD_NS)
`define MODE_LOAD_DELAY_CYC `CYC_UP(`MODE_LOAD_DELAY_NS)
`define SELF_REFRESH_EXIT_DELAY_CYC `CYC_UP(`SELF_REFRESH_EXIT_DELAY_NS)

`endif

// *** hw/cmd_decode.v ***
// strobe decoder: turns the four command strobes into a command code
// assumes the strobes are synchronous to the system clock
`timescale 1ns/100ps
`default_nettype none
`include "bank_cmd_regs.vh"

module cmd_decode (
    // strobes
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    // decoded
    output wire [2:0] cmd
);
    // ==========================================================
    // deselect reads as a no-operation
    assign cmd = cs_n ? `CMD_NOP : {ras_n, cas_n, we_n};
endmodule
`default_nettype wire

// *** hw/bank_timer.v ***
// one bank's state register and countdown timer
// assumes the parent gives a one-cycle load with state and count
`timescale 1ns/100ps
`default_nettype none
`include "bank_cmd_regs.vh"

module bank_timer #(
    parameter CW = 4
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // load
    input wire load,
    input wire [2:0] load_state,
    input wire [CW-1:0] load_count,
    // state
    output reg [2:0] state_r,
    output wire busy
);
    reg [CW-1:0] count_r;

    assign busy = (count_r != {CW{1'b0}});

    // ==========================================================
    // timed states fall to their follow-on state when the count ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `BS_IDLE;
            count_r <= {CW{1'b0}};
        end else if (load) begin
            state_r <= load_state;
            count_r <= load_count;
        end else if (count_r > {{(CW-1){1'b0}}, 1'b1}) begin
            count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
        end else if (busy) begin
            count_r <= {CW{1'b0}};
            case (state_r)
                `BS_ACTIVATING: state_r <= `BS_ACTIVE;
                `BS_PRECHARGING: state_r <= `BS_IDLE;
                `BS_AUTO_PRE: state_r <= `BS_IDLE;
                default: state_r <= state_r;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hw/bank_legality.v ***
// bank state tracking and command legality for a four-bank SDRAM
// assumes the controller drives strobes synchronous to CLK_SYS
`timescale 1ns/100ps
`default_nettype none
`include "bank_cmd_regs.vh"

// Behaviour
// - deselect or nop continues current operation
// - idle bank decodes activate row
// - precharge to idle bank is nop
// - active bank accepts read and write
// - both auto precharge variants accepted
// - access restarts plain burst at new column
// - precharge truncates read, starts precharging
// - precharge truncates write, starts precharging
// - terminate stops most recent burst if it is plain
// - rules apply only with cke high twice
// - idle only after precharge period
// - active only after activate delay, no burst
// - precharging ends after precharge period
// - activating ends after activate delay
// - auto precharge access idles after period
// - refresh busy for refresh cycle period
// - mode load busy for mode load delay
// - precharge all busies every bank
// - top address line selects auto precharge
module bank_legality #(
    parameter BURST_CYC = 4,
    parameter CW = 4,
    parameter DW = 4
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RSTN,
    // command strobes
    input wire CKE,
    input wire CS_N,
    input wire RAS_N,
    input wire CAS_N,
    input wire WE_N,
    input wire [1:0] BANK,
    input wire AUTO_PRECHARGE_SELECT,
    // state out
    output wire [11:0] BANK_STATE,
    output wire [1:0] DEV_PHASE,
    output wire ALL_IDLE,
    output reg ILLEGAL_R,
    output reg ACCEPTED_R
);
    // ==========================================================
    // decode
    wire [2:0] cmd;
    reg cke_prev_r;
    reg [1:0] phase_r;
    reg [DW-1:0] dev_count_r;
    reg [1:0] last_bank_r;
    reg last_valid_r;
    reg [CW-1:0] burst_r [0:3];
    reg [3:0] load;
    reg [2:0] load_state [0:3];
    reg [CW-1:0] load_count [0:3];
    reg illegal_nxt;
    reg [1:0] phase_nxt;
    reg [DW-1:0] dev_count_nxt;
    wire [2:0] st [0:3];
    wire [3:0] busy;
    wire [2:0] cur;
    wire live;
    reg idle_pre;
    integer i;

    // cycle counts kept 32 bits wide here and cut to the counter width
    // by part-select where they are loaded
    localparam [31:0] PRE_CYC = `PRECHARGE_PERIOD_CYC;
    localparam [31:0] ACT_CYC = `ACTIVATE_TO_ACCESS_DELAY_CYC;
    localparam [31:0] REF_CYC = `REFRESH_CYCLE_PERIOD_CYC;
    localparam [31:0] MRS_CYC = `MODE_LOAD_DELAY_CYC;
    localparam [31:0] SRX_CYC = `SELF_REFRESH_EXIT_DELAY_CYC;

    cmd_decode cmd_decode_inst (
        .cs_n(CS_N),
        .ras_n(RAS_N),
        .cas_n(CAS_N),
        .we_n(WE_N),
        .cmd(cmd)
    );

    // ==========================================================
    // per-bank timers
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gb
            bank_timer #(.CW(CW)) bank_timer_inst (
                .clk(CLK_SYS),
                .rst_n(RSTN),
                .load(load[g]),
                .load_state(load_state[g]),
                .load_count(load_count[g]),
                .state_r(st[g]),
                .busy(busy[g])
            );
            assign BANK_STATE[3*g +: 3] = st[g];
        end
    endgenerate

    function is_idle;
        input [2:0] s;
        begin
            is_idle = (s == `BS_IDLE);
        end
    endfunction

    // a bank that may take a precharge: idle, active or in a plain burst
    function pre_ok;
        input [2:0] s;
        begin
            pre_ok = (s == `BS_ACTIVE) || (s == `BS_READ) ||
                (s == `BS_WRITE) || (s == `BS_IDLE);
        end
    endfunction

    assign cur = st[BANK];
    // only edges with cke high now and before, outside busy phases
    assign live = CKE && cke_prev_r && (phase_r == `DEV_NORMAL);
    assign ALL_IDLE = is_idle(st[0]) && is_idle(st[1]) &&
        is_idle(st[2]) && is_idle(st[3]) && (phase_r == `DEV_NORMAL);
    assign DEV_PHASE = phase_r;

    // ==========================================================
    // command legality and bank loads
    always @* begin
        illegal_nxt = 1'b0;
        idle_pre = 1'b0;
        phase_nxt = phase_r;
        dev_count_nxt = dev_count_r;
        for (i = 0; i < 4; i = i + 1) begin
            load[i] = 1'b0;
            load_state[i] = st[i];
            load_count[i] = {CW{1'b0}};
        end
        if (!live) begin
            // any command other than nop in a busy phase is refused
            if (CKE && cke_prev_r && cmd != `CMD_NOP) begin
                illegal_nxt = 1'b1;
            end
        end else begin
            case (cmd)
                `CMD_NOP: begin
                    illegal_nxt = 1'b0;
                end
                `CMD_ACT: begin
                    if (is_idle(cur)) begin
                        load[BANK] = 1'b1;
                        load_state[BANK] = `BS_ACTIVATING;
                        load_count[BANK] = ACT_CYC[CW-1:0];
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
                `CMD_READ, `CMD_WRITE: begin
                    // active or plain burst: new burst at new column
                    if (cur == `BS_ACTIVE || cur == `BS_READ ||
                        cur == `BS_WRITE) begin
                        load[BANK] = 1'b1;
                        if (AUTO_PRECHARGE_SELECT) begin
                            load_state[BANK] = `BS_AUTO_PRE;
                            load_count[BANK] = BURST_CYC[CW-1:0] +
                                PRE_CYC[CW-1:0];
                        end else begin
                            load_state[BANK] = (cmd == `CMD_READ) ?
                                `BS_READ : `BS_WRITE;
                        end
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
                `CMD_TERM: begin
                    // stop the latest burst whatever its bank, if it is a plain one
                    if (last_valid_r && (st[last_bank_r] == `BS_READ ||
                        st[last_bank_r] == `BS_WRITE)) begin
                        load[last_bank_r] = 1'b1;
                        load_state[last_bank_r] = `BS_ACTIVE;
                    end
                end
                `CMD_PRE: begin
                    if (AUTO_PRECHARGE_SELECT) begin
                        if (pre_ok(st[0]) && pre_ok(st[1]) &&
                            pre_ok(st[2]) && pre_ok(st[3])) begin
                            for (i = 0; i < 4; i = i + 1) begin
                                load[i] = 1'b1;
                                load_state[i] = `BS_PRECHARGING;
                                load_count[i] = PRE_CYC[CW-1:0];
                            end
                        end else begin
                            illegal_nxt = 1'b1;
                        end
                    end else if (is_idle(cur)) begin
                        // silent: neither accepted nor refused
                        idle_pre = 1'b1;
                    end else if (pre_ok(cur)) begin
                        load[BANK] = 1'b1;
                        load_state[BANK] = `BS_PRECHARGING;
                        load_count[BANK] = PRE_CYC[CW-1:0];
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
                `CMD_REF: begin
                    if (ALL_IDLE) begin
                        phase_nxt = `DEV_REFRESH;
                        dev_count_nxt = REF_CYC[DW-1:0];
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
                default: begin
                    if (ALL_IDLE) begin
                        phase_nxt = `DEV_MODE_LOAD;
                        dev_count_nxt = MRS_CYC[DW-1:0];
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
            endcase
        end
        // leaving a low-cke period waits out the self refresh exit delay
        if (CKE && !cke_prev_r) begin
            phase_nxt = `DEV_SR_EXIT;
            dev_count_nxt = SRX_CYC[DW-1:0];
        end else if (phase_r != `DEV_NORMAL) begin
            if (dev_count_r > {{(DW-1){1'b0}}, 1'b1}) begin
                dev_count_nxt = dev_count_r - {{(DW-1){1'b0}}, 1'b1};
            end else begin
                dev_count_nxt = {DW{1'b0}};
                phase_nxt = `DEV_NORMAL;
            end
        end
    end

    // ==========================================================
    // shared timer, last burst bank and status flags
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cke_prev_r <= 1'b1;
            phase_r <= `DEV_NORMAL;
            dev_count_r <= {DW{1'b0}};
            last_bank_r <= 2'h0;
            last_valid_r <= 1'b0;
            ILLEGAL_R <= 1'b0;
            ACCEPTED_R <= 1'b0;
        end else begin
            cke_prev_r <= CKE;
            phase_r <= phase_nxt;
            dev_count_r <= dev_count_nxt;
            ILLEGAL_R <= illegal_nxt;
            ACCEPTED_R <= live && (cmd != `CMD_NOP) && !illegal_nxt &&
                !idle_pre;
            if (live && !illegal_nxt &&
                (cmd == `CMD_READ || cmd == `CMD_WRITE)) begin
                last_bank_r <= BANK;
                last_valid_r <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/legality_chk_sva.sv ***
// checker: bank state and flag timing at the top-level ports
// assumes the header codes and a single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "bank_cmd_regs.vh"
module legality_chk (
    // clock and reset
    input wire CLK_SYS,
    input wire RSTN,
    // strobes
    input wire CKE,
    input wire CS_N,
    input wire RAS_N,
    input wire CAS_N,
    input wire WE_N,
    input wire [1:0] BANK,
    input wire AUTO_PRECHARGE_SELECT,
    // state
    input wire [11:0] BANK_STATE,
    input wire [1:0] DEV_PHASE,
    input wire ALL_IDLE,
    input wire ILLEGAL_R,
    input wire ACCEPTED_R
);
    // ==========================================
    // helpers: only bank 0 is watched, to keep the checker small
    reg cke_r;
    wire [2:0] cmd = {RAS_N, CAS_N, WE_N};
    wire [2:0] b0 = BANK_STATE[2:0];
    wire go = CKE && cke_r && DEV_PHASE == `DEV_NORMAL && !CS_N;
    wire g0 = go && BANK == 2'h0;
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) cke_r <= 1'b1;
        else cke_r <= CKE;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // ==========================================
    // assertions
    act_idle_a: assert property (g0 && cmd == `CMD_ACT && b0 == `BS_IDLE
        |=> b0 == `BS_ACTIVATING && ACCEPTED_R) else $error("no activate");
    act_len_a: assert property ($rose(b0 == `BS_ACTIVATING)
        |=> b0 == `BS_ACTIVATING ##1 b0 == `BS_ACTIVE)
        else $error("activate delay");
    pre_len_a: assert property ($rose(b0 == `BS_PRECHARGING)
        |=> b0 == `BS_PRECHARGING ##1 b0 == `BS_IDLE)
        else $error("precharge period");
    pre_nop_a: assert property (g0 && cmd == `CMD_PRE && b0 == 3'h0
        && !AUTO_PRECHARGE_SELECT |=> b0 == `BS_IDLE && !ACCEPTED_R
        && !ILLEGAL_R) else $error("precharge idle");
    access_a: assert property (g0 && cmd[2:1] == 2'h2 && b0 >= 3'h2
        && b0 <= 3'h4 |=> b0 == ($past(AUTO_PRECHARGE_SELECT) ? 3'h6
        : $past(WE_N) ? `BS_READ : `BS_WRITE)) else $error("access");
    pre_trunc_a: assert property (g0 && cmd == `CMD_PRE && b0 >= 3'h3
        && b0 <= 3'h4 && !AUTO_PRECHARGE_SELECT
        |=> b0 == `BS_PRECHARGING) else $error("truncate");
    refresh_len_a: assert property (go && cmd == `CMD_REF && ALL_IDLE
        |=> DEV_PHASE == `DEV_REFRESH [*6] ##1 ALL_IDLE)
        else $error("refresh period");
    mode_len_a: assert property (go && cmd == `CMD_MRS && ALL_IDLE
        |=> DEV_PHASE == `DEV_MODE_LOAD [*2] ##1 ALL_IDLE)
        else $error("mode load delay");
    nop_quiet_a: assert property (CS_N || cmd == `CMD_NOP
        |=> !ACCEPTED_R && !ILLEGAL_R) else $error("nop flagged");
    // main scenarios
    cover property (go && cmd == `CMD_REF);
    cover property (b0 == `BS_AUTO_PRE);
    cover property (ILLEGAL_R);
endmodule
bind bank_legality legality_chk legality_chk_inst (.CLK_SYS, .RSTN, .CKE,
    .CS_N, .RAS_N, .CAS_N, .WE_N, .BANK, .AUTO_PRECHARGE_SELECT,
    .BANK_STATE, .DEV_PHASE, .ALL_IDLE, .ILLEGAL_R, .ACCEPTED_R);
`default_nettype wire

// *** testbench/ctrl_model.sv ***
// partner: memory controller driving the command strobes
// assumes the bench calls its tasks; pins move at falling edges only
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
    // clock
    input wire clk,
    // command pins
    output logic CKE,
    output logic CS_N,
    output logic RAS_N,
    output logic CAS_N,
    output logic WE_N,
    output logic [1:0] BANK,
    output logic AUTO_PRECHARGE_SELECT
);
    // ==========================================
    // deselected with clock enabled until told otherwise
    initial begin
        {CKE, CS_N, RAS_N, CAS_N, WE_N} = 5'h1F;
        {BANK, AUTO_PRECHARGE_SELECT} = 3'h0;
    end
    // one command, held until the next falling edge
    task issue(input logic [2:0] k, input logic [1:0] b, input logic ap);
        @(negedge clk);
        CS_N = 1'b0;
        {RAS_N, CAS_N, WE_N} = k;
        BANK = b;
        AUTO_PRECHARGE_SELECT = ap;
    endtask
    // deselect; the rest flips so a stale value never looks valid
    task gap(input int n);
        repeat (n) begin
            @(negedge clk);
            CS_N = 1'b1;
            {RAS_N, CAS_N, WE_N} = ~{RAS_N, CAS_N, WE_N};
            {BANK, AUTO_PRECHARGE_SELECT} = ~{BANK, AUTO_PRECHARGE_SELECT};
        end
    endtask
    // clock enable moves only while deselected
    task cke_set(input logic v);
        @(negedge clk);
        CKE = v;
    endtask
endmodule
`default_nettype wire

// *** testbench/bank_legality_tb_top.sv ***
// bench: hand-written scenarios for bank command legality
// assumes the controller model and the header's codes
`timescale 1ns/100ps
`default_nettype none
`include "bank_cmd_regs.vh"
module bank_legality_tb_top;
    localparam int BURST = 4;
    logic CLK_SYS;
    logic RSTN;
    wire CKE, CS_N, RAS_N, CAS_N, WE_N, AUTO_PRECHARGE_SELECT;
    wire [1:0] BANK, DEV_PHASE;
    wire [11:0] BANK_STATE;
    wire ALL_IDLE, ILLEGAL_R, ACCEPTED_R;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // ==========================================
    // design and controller model
    bank_legality #(.BURST_CYC(BURST)) bank_legality_inst (.CLK_SYS,
        .RSTN, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BANK,
        .AUTO_PRECHARGE_SELECT, .BANK_STATE, .DEV_PHASE, .ALL_IDLE,
        .ILLEGAL_R, .ACCEPTED_R);
    ctrl_model ctrl_model_inst (.clk(CLK_SYS), .CKE, .CS_N, .RAS_N,
        .CAS_N, .WE_N, .BANK, .AUTO_PRECHARGE_SELECT);
    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    // ==========================================
    // helpers; a model task returns just after the previous edge
    // wide enough for the flags packed above the 12 state bits
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    function logic [2:0] st(input int b);
        st = BANK_STATE[b*3 +: 3];
    endfunction
    task c(input logic [2:0] k, input logic [1:0] b, input logic ap);
        ctrl_model_inst.issue(k, b, ap);
    endtask
    task g(input int n);
        ctrl_model_inst.gap(n);
    endtask
    // phase holds n cycles, then back to normal
    task ph(input int n, input logic [1:0] p);
        for (int i = 0; i < n; i++) begin
            g(1);
            chk(DEV_PHASE, p);
        end
        g(1);
        chk(ALL_IDLE, 1'b1);
    endtask
    // ==========================================
    // scenarios
    task t_walk;
        c(`CMD_ACT, 2'h0, 1'b0);
        g(1);
        chk(st(0), `BS_ACTIVATING);
        g(1);
        chk(st(0), `BS_ACTIVATING);
        c(`CMD_READ, 2'h0, 1'b0);
        chk(st(0), `BS_ACTIVE);
        c(`CMD_READ, 2'h0, 1'b0);
        chk(st(0), `BS_READ);
        c(`CMD_WRITE, 2'h0, 1'b0);
        chk({ACCEPTED_R, st(0)}, 4'hB);
        c(`CMD_TERM, 2'h0, 1'b0);
        chk(st(0), `BS_WRITE);
        c(`CMD_READ, 2'h0, 1'b0);
        chk(st(0), `BS_ACTIVE);
        c(`CMD_PRE, 2'h0, 1'b0);
        g(1);
        chk(st(0), `BS_PRECHARGING);
        g(1);
        chk(st(0), `BS_PRECHARGING);
        g(1);
        chk(st(0), `BS_IDLE);
        $display("done walk");
    endtask
    task t_ap;
        int n;
        for (int i = 0; i < 2; i++) begin
            n = 0;
            c(`CMD_ACT, 2'h1, 1'b0);
            g(2);
            c(i ? `CMD_WRITE : `CMD_READ, 2'h1, 1'b1);
            g(1);
            while (st(1) === `BS_AUTO_PRE && n < 20) begin
                n++;
                g(1);
            end
            chk(n, BURST + 2);
            chk(st(1), `BS_IDLE);
        end
        $display("done auto precharge");
    endtask
    task t_busy;
        c(`CMD_ACT, 2'h2, 1'b0);
        c(`CMD_WRITE, 2'h2, 1'b0); // too early on purpose
        c(`CMD_ACT, 2'h3, 1'b0); // other bank
        chk({ILLEGAL_R, st(2)}, 4'h9);
        c(`CMD_WRITE, 2'h2, 1'b0);
        c(`CMD_PRE, 2'h2, 1'b0);
        chk({ACCEPTED_R, st(2)}, 4'hC);
        g(3);
        chk(st(2), `BS_IDLE);
        c(`CMD_PRE, 2'h0, 1'b1); // all banks in a precharge-legal state
        g(1);
        chk(st(3), `BS_PRECHARGING);
        g(2);
        chk({ALL_IDLE, BANK_STATE}, 13'h1000);
        $display("done busy");
    endtask
    task t_nop;
        c(`CMD_PRE, 2'h0, 1'b0);
        g(1);
        chk({ACCEPTED_R, ILLEGAL_R, st(0)}, 5'h00);
        $display("done idle precharge");
    endtask
    task t_phase;
        c(`CMD_REF, 2'h0, 1'b0); // all idle
        ph(6, `DEV_REFRESH);
        c(`CMD_MRS, 2'h0, 1'b0);
        ph(2, `DEV_MODE_LOAD);
        ctrl_model_inst.cke_set(1'b0);
        g(2);
        ctrl_model_inst.cke_set(1'b1);
        ph(7, `DEV_SR_EXIT);
        $display("done phases");
    endtask
    // ==========================================
    // verdict, also reached by the cycle ceiling
    task stop_test;
        $display("comparisons %0d bad %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        RSTN = 1'b0;
        repeat (6) @(negedge CLK_SYS);
        RSTN = 1'b1;
        t_walk();
        t_ap();
        t_busy();
        t_nop();
        t_phase();
        g(2);
        stop_test();
    end
endmodule
`default_nettype wire
